// ---- hw/uabd_device.sv ----
// device end: apb register file and auto-rate measurement of a sync character
`timescale 1ns/1ps
// Operation
// - receive edges time the divisor counter
// - arm bit starts sequence, receiver held idle
// - counting starts at first rise after start
// - fifth rise stops, clears arm, sets pending
// - software reads holding register, discards value
// - software checks high byte zero for 8-bit
// - both divisor bytes form one 16-bit counter
// - counter clocked at one eighth base rate
// - with wake enable, measure character after break
// - software keeps rate within measurable range
// - count starts at one; software subtracts one
// - prescale 512, 128, 128, 32 by selections
module uabd_device (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic rx_idle_o,
    uabd_link_if.device link
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_BREAK = 3'b001,
        ST_WAIT_START = 3'b010,
        ST_WAIT_RISE = 3'b011,
        ST_COUNT = 3'b100
    } uabd_state_e;

    // ==========================================================
    // registers
    uabd_state_e state_q;
    logic arm_q, wake_q, wide_q, fast_q, ovf_q, pend_q;
    logic [15:0] divisor_q;
    logic [7:0] rx_hold_q;
    logic [6:0] ctrl_spare_q;
    logic [8:0] pre_q;
    logic [2:0] rises_q;
    logic rx_meta_q, rx_sync_q, rx_prev_q;

    // ==========================================================
    // receive line synchroniser, then edge detection off the second stage only
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end else if (clk_en_i) begin
            rx_meta_q <= link.rx_line;
            rx_sync_q <= rx_meta_q;
            rx_prev_q <= rx_sync_q;
        end
    end

    logic rise, fall;
    assign rise = rx_sync_q && !rx_prev_q;
    assign fall = !rx_sync_q && rx_prev_q;

    // ==========================================================
    // apb decode: zero wait states, unmapped addresses answer slverr
    logic acc, wr, rd, mapped;
    assign acc = psel_i && penable_i && clk_en_i;
    assign wr = acc && pwrite_i;
    assign rd = acc && !pwrite_i;
    assign pready_o = 1'b1;
    always_comb begin
        mapped = 1'b1;
        case (paddr_i)
            uabd_pkg::OFS_BAUD_CONTROL, uabd_pkg::OFS_RX_STATUS, uabd_pkg::OFS_DIVISOR_LOW,
            uabd_pkg::OFS_DIVISOR_HIGH, uabd_pkg::OFS_RX_HOLDING, uabd_pkg::OFS_TX_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pslverr_o = psel_i && penable_i && !mapped;

    // read data mux, registered output is not needed: apb samples at access edge
    logic [7:0] rbyte;
    always_comb begin
        rbyte = uabd_pkg::RST_BYTE;
        case (paddr_i)
            uabd_pkg::OFS_BAUD_CONTROL: begin
                rbyte = {ovf_q, (state_q == ST_IDLE), 2'b00, wide_q, 1'b0, wake_q, arm_q};
            end
            uabd_pkg::OFS_RX_STATUS: rbyte = {ctrl_spare_q, pend_q};
            uabd_pkg::OFS_DIVISOR_LOW: rbyte = divisor_q[7:0];
            uabd_pkg::OFS_DIVISOR_HIGH: rbyte = divisor_q[15:8];
            uabd_pkg::OFS_RX_HOLDING: rbyte = rx_hold_q;
            uabd_pkg::OFS_TX_STATUS: rbyte = {5'h00, fast_q, 2'b00};
            default: rbyte = uabd_pkg::RST_BYTE;
        endcase
    end
    assign prdata_o = {24'h000000, rbyte};

    // ==========================================================
    // control bits written by software; spare bits are simply stored
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wake_q <= 1'b0;
            wide_q <= 1'b0;
            fast_q <= 1'b0;
            ctrl_spare_q <= 7'h00;
            rx_hold_q <= uabd_pkg::RST_BYTE;
        end else if (clk_en_i) begin
            if (wr && paddr_i == uabd_pkg::OFS_BAUD_CONTROL) begin
                wake_q <= pwdata_i[uabd_pkg::BIT_WAKE_ON_BREAK];
                wide_q <= pwdata_i[uabd_pkg::BIT_WIDE_DIVIDER];
            end
            if (wr && paddr_i == uabd_pkg::OFS_TX_STATUS) begin
                fast_q <= pwdata_i[uabd_pkg::BIT_HIGH_SPEED];
            end
            if (wr && paddr_i == uabd_pkg::OFS_RX_STATUS) begin
                ctrl_spare_q <= pwdata_i[7:1];
            end
        end
    end

    // ==========================================================
    // measurement tick: prescale by 512/128/32, i.e. base clock over eight
    logic tick;
    assign tick = (pre_q == uabd_pkg::meas_div(wide_q, fast_q));
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pre_q <= 9'h000;
        end else if (clk_en_i) begin
            if (state_q != ST_COUNT || tick) begin
                pre_q <= 9'h000;
            end else begin
                pre_q <= pre_q + 9'h001;
            end
        end
    end

    // ==========================================================
    // sequence state, arm, divisor counter, overflow, pending
    logic done;
    assign done = (state_q == ST_COUNT) && rise && (rises_q == uabd_pkg::RISE_LAST - 3'h1);
    assign rx_idle_o = (state_q == ST_IDLE);

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= ST_IDLE;
            arm_q <= 1'b0;
            ovf_q <= 1'b0;
            pend_q <= 1'b0;
            rises_q <= 3'h0;
            divisor_q <= uabd_pkg::RST_DIVISOR;
        end else if (clk_en_i) begin
            case (state_q)
                ST_IDLE: begin
                    if (wr && paddr_i == uabd_pkg::OFS_BAUD_CONTROL && pwdata_i[uabd_pkg::BIT_AUTORATE_ARM]) begin
                        arm_q <= 1'b1;
                        // wake enable: skip the break, measure the next character
                        state_q <= pwdata_i[uabd_pkg::BIT_WAKE_ON_BREAK] ? ST_BREAK : ST_WAIT_START;
                    end
                end
                ST_BREAK: begin
                    if (rise) begin
                        state_q <= ST_WAIT_START;
                    end
                end
                ST_WAIT_START: begin
                    if (fall) begin
                        state_q <= ST_WAIT_RISE;
                    end
                end
                ST_WAIT_RISE: begin
                    if (rise) begin
                        state_q <= ST_COUNT;
                        divisor_q <= uabd_pkg::MEASURE_START;
                        rises_q <= 3'h1;
                    end
                end
                ST_COUNT: begin
                    if (done) begin
                        state_q <= ST_IDLE;
                        arm_q <= 1'b0;
                    end else begin
                        if (rise) begin
                            rises_q <= rises_q + 3'h1;
                        end
                        if (tick) begin
                            divisor_q <= divisor_q + 16'h0001;
                            if (divisor_q == 16'hffff) begin
                                ovf_q <= 1'b1;
                            end
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
            // software writes: divisor bytes only while idle; overflow cleared by writing zero
            if (state_q == ST_IDLE && wr && paddr_i == uabd_pkg::OFS_DIVISOR_LOW) begin
                divisor_q[7:0] <= pwdata_i[7:0];
            end
            if (state_q == ST_IDLE && wr && paddr_i == uabd_pkg::OFS_DIVISOR_HIGH) begin
                divisor_q[15:8] <= pwdata_i[7:0];
            end
            if (wr && paddr_i == uabd_pkg::OFS_BAUD_CONTROL && !pwdata_i[uabd_pkg::BIT_AUTORATE_OVF]
                && !(state_q == ST_COUNT && tick && divisor_q == 16'hffff)) begin
                ovf_q <= 1'b0;
            end
            // pending: set wins over the clearing read
            if (done) begin
                pend_q <= 1'b1;
            end else if (rd && paddr_i == uabd_pkg::OFS_RX_HOLDING) begin
                pend_q <= 1'b0;
            end
        end
    end
endmodule : uabd_device

// ---- common/uabd_pkg.sv ----
// package: register map, field positions and timing for the auto-rate measurement block
package uabd_pkg;
    // ==========================================================
    // register offsets (byte addresses, one word each)
    localparam logic [7:0] OFS_BAUD_CONTROL = 8'h00;
    localparam logic [7:0] OFS_RX_STATUS = 8'h04;
    localparam logic [7:0] OFS_DIVISOR_LOW = 8'h08;
    localparam logic [7:0] OFS_DIVISOR_HIGH = 8'h0c;
    localparam logic [7:0] OFS_RX_HOLDING = 8'h10;
    localparam logic [7:0] OFS_TX_STATUS = 8'h14;
    // ==========================================================
    // field positions
    localparam int BIT_AUTORATE_ARM = 0;
    localparam int BIT_WAKE_ON_BREAK = 1;
    localparam int BIT_WIDE_DIVIDER = 3;
    localparam int BIT_AUTORATE_OVF = 7;
    localparam int BIT_RX_PENDING = 0;
    localparam int BIT_HIGH_SPEED = 2;
    // ==========================================================
    // reset values, count start value and last counted rise
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_DIVISOR = 16'h0000;
    localparam logic [15:0] MEASURE_START = 16'h0001;
    localparam logic [2:0] RISE_LAST = 3'h5;
    // ==========================================================
    // measurement prescale terminal counts (divide minus one)
    localparam logic [8:0] DIV_512 = 9'h1ff;
    localparam logic [8:0] DIV_128 = 9'h07f;
    localparam logic [8:0] DIV_32 = 9'h01f;

    // measurement clock period select from wide-divider and high-speed bits
    function automatic logic [8:0] meas_div(input logic wide, input logic fast);
        logic [8:0] r;
        r = DIV_128;
        if (!wide && !fast) begin
            r = DIV_512;
        end else if (wide && fast) begin
            r = DIV_32;
        end
        return r;
    endfunction : meas_div
endpackage : uabd_pkg

// ---- common/uabd_link_if.sv ----
// interface: serial receive line between remote transmitter and device
`timescale 1ns/1ps
interface uabd_link_if;
    logic rx_line;
    modport device (input rx_line);
    modport remote (output rx_line);
endinterface : uabd_link_if

// ---- hw/uabd_remote.sv ----
// remote node: sends a break (optional) and then the 55h sync character
`timescale 1ns/1ps
module uabd_remote (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic send_i,
    input wire logic with_break_i,
    input wire logic [15:0] bit_cycles_i,
    output logic busy_o,
    uabd_link_if.remote link
);
    // ==========================================================
    // frame shift: break (13 zero bits + 1 stop) then start, 55h lsb first, stop
    logic [23:0] frame_q;
    logic [4:0] bits_left_q;
    logic [15:0] cnt_q;
    logic line_q;

    // busy lasts through the whole last bit, so a new frame cannot cut the final stop bit short
    assign busy_o = (bits_left_q != 5'h00) || (cnt_q != 16'h0000);
    assign link.rx_line = line_q;

    // bit timing and shifting
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            frame_q <= 24'h000000;
            bits_left_q <= 5'h00;
            cnt_q <= 16'h0000;
            line_q <= 1'b1;
        end else if (clk_en_i) begin
            if (!busy_o) begin
                line_q <= 1'b1;
                if (send_i) begin
                    // break frame is prefixed only when asked
                    frame_q <= with_break_i ? {1'b1, 8'h55, 1'b0, 1'b1, 13'h0000} : {13'h1fff, 2'b11, 8'h55, 1'b0};
                    bits_left_q <= with_break_i ? 5'h18 : 5'h0b;
                    cnt_q <= 16'h0000;
                end
            end else if (cnt_q == 16'h0000) begin
                line_q <= frame_q[0];
                frame_q <= {1'b1, frame_q[23:1]};
                cnt_q <= bit_cycles_i;
                bits_left_q <= bits_left_q - 5'h01;
            end else begin
                cnt_q <= cnt_q - 16'h0001;
            end
        end
    end
endmodule : uabd_remote

// ---- verif/uabd_asserts.sv ----
// checker: apb and link relations of the auto-rate block
`timescale 1ns/1ps
module uabd_asserts (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic rx_line,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic rx_idle_o,
    input wire logic busy_o
);
    // ==========================================================
    // access decode, kept apart so each property stays short
    wire logic acc = psel_i & penable_i;
    wire logic rd = acc & !pwrite_i;
    wire logic ctl = paddr_i == uabd_pkg::OFS_BAUD_CONTROL;
    wire logic hit = paddr_i <= 8'h14 && paddr_i[1:0] == 2'h0;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    // ==========================================================
    // sequence control
    property p_arm; acc && pwrite_i && ctl && pwdata_i[0] |=> !rx_idle_o; endproperty
    a_arm: assert property (p_arm) else $error("receiver not held after arming");
    property p_idle_bit; rd && ctl |-> prdata_o[6] == rx_idle_o; endproperty
    a_idle_bit: assert property (p_idle_bit) else $error("idle bit differs from idle port");
    property p_arm_bit; rd && ctl |-> prdata_o[0] != rx_idle_o; endproperty
    a_arm_bit: assert property (p_arm_bit) else $error("arm bit not cleared at end");
    // completion lands on the stop bit, while the far end still sends it
    property p_done; $rose(rx_idle_o) |-> rx_line && busy_o; endproperty
    a_done: assert property (p_done) else $error("sequence ended off the stop bit");
    // only a line edge may end a measurement; six cycles covers the sync delay
    property p_hold; (!rx_idle_o && $stable(rx_line)) [*6] |=> !rx_idle_o; endproperty
    a_hold: assert property (p_hold) else $error("measurement ended without a line edge");
    // ==========================================================
    // bus answers
    property p_holding; rd && paddr_i == uabd_pkg::OFS_RX_HOLDING |-> prdata_o == 32'h0; endproperty
    a_holding: assert property (p_holding) else $error("holding read not zero");
    property p_ready; acc |-> pready_o; endproperty
    a_ready: assert property (p_ready) else $error("access phase without ready");
    property p_err; acc |-> pslverr_o == !hit; endproperty
    a_err: assert property (p_err) else $error("error response wrong for address");
    property p_upper; rd |-> prdata_o[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("read data above byte not zero");
endmodule : uabd_asserts

// ---- verif/uabd_tb.sv ----
// testbench: both ends joined, apb stimulus, wire and divisor checks
`timescale 1ns/1ps
module uabd_tb;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic send = 1'b0;
    logic brk = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] bits = 16'h0;
    logic [31:0] seed = 32'hbc7381b2;
    logic [31:0] prdata;
    logic pready, pslverr, rx_idle, busy;
    logic [32:0] expq[$];
    int n_mismatch = 0;
    int comparisons = 0;
    uabd_link_if i_uabd_link_if ();
    wire logic line = i_uabd_link_if.rx_line;
    uabd_device i_uabd_device (.clock_i(clock_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .rx_idle_o(rx_idle), .link(i_uabd_link_if.device));
    uabd_remote i_uabd_remote (.clock_i(clock_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1), .send_i(send),
        .with_break_i(brk), .bit_cycles_i(bits), .busy_o(busy), .link(i_uabd_link_if.remote));
    uabd_asserts i_uabd_asserts (.clock_i(clock_i), .reset_n_i(reset_n_i), .rx_line(line), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .rx_idle_o(rx_idle), .busy_o(busy));
    always #5 clock_i = ~clock_i;
    // ==========================================================
    // helpers; bit 32 of an expectation allows one count either way (prescale phase)
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] got, input logic [32:0] e);
        comparisons++;
        if (got !== e[31:0] && !(e[32] && (got === e[31:0] + 1 || got === e[31:0] - 1))) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, e[31:0]);
        end
    endtask : chk
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    // one apb transfer, entered just after a rising edge; idle cycle after release
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        @(posedge clock_i);
        while (pready !== 1'b1) @(posedge clock_i);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock_i);
    endtask : xfer
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        expq.push_back(e);
        xfer(a, 1'b0, 32'h0);
    endtask : rd
    // monitor: read data is taken at the edge that completes the access
    always @(posedge clock_i) begin
        if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0) begin
            chk(prdata, expq.pop_front());
        end
    end
    // watchdog: the longest mode frame plus margin stays below this span
    initial begin
        repeat (95000) @(posedge clock_i);
        n_mismatch++;
        print_verdict();
    end
    // ==========================================================
    // main sequence
    initial begin
        int t, p, e, n;
        logic [9:0] w;
        logic wide, fast;
        repeat (20) @(posedge clock_i);
        reset_n_i <= 1'b1;
        @(posedge clock_i);
        rd(uabd_pkg::OFS_BAUD_CONTROL, 33'h40);
        for (int a = 4; a <= 24; a += 4) rd(a[7:0], 33'h0);
        // spare status bits are plain storage; put them back to zero afterwards
        xfer(uabd_pkg::OFS_RX_STATUS, 1'b1, 32'hfe);
        rd(uabd_pkg::OFS_RX_STATUS, 33'hfe);
        xfer(uabd_pkg::OFS_RX_STATUS, 1'b1, 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 5; i++) begin
            {wide, fast} = (i == 4) ? 2'b01 : i[1:0];
            p = (wide && fast) ? 32 : (wide || fast) ? 128 : 512;
            seed = lfsr(seed);
            t = (i == 4) ? 4160 : 64 * (seed[2:0] + 1);
            e = 1 + 8 * t / p;
            xfer(uabd_pkg::OFS_TX_STATUS, 1'b1, {29'h0, fast, 2'h0});
            xfer(uabd_pkg::OFS_BAUD_CONTROL, 1'b1, {28'h0, wide, 1'b0, i == 2, 1'b1});
            rd(uabd_pkg::OFS_BAUD_CONTROL, {29'h0, wide, 1'b0, i == 2, 1'b1});
            xfer(uabd_pkg::OFS_DIVISOR_LOW, 1'b1, 32'hff);
            // a send while the previous frame still goes out would be ignored
            while (busy !== 1'b0) @(posedge clock_i);
            bits <= 16'(t - 1);
            brk <= (i == 2);
            send <= 1'b1;
            @(posedge clock_i);
            send <= 1'b0;
            n = 0;
            while (i != 2 && line !== 1'b0 && n < 60000) begin
                @(posedge clock_i);
                n++;
            end
            if (i != 2) begin
                repeat (t / 2) @(posedge clock_i);
                for (int k = 0; k < 10; k++) begin
                    w[k] = line;
                    repeat (t) @(posedge clock_i);
                end
                chk({22'h0, w}, 33'h2aa);
            end
            n = 0;
            while (rx_idle !== 1'b1 && n < 60000) begin
                @(posedge clock_i);
                n++;
            end
            chk({31'h0, rx_idle}, 33'h1);
            rd(uabd_pkg::OFS_DIVISOR_LOW, {1'b1, 24'h0, e[7:0]});
            rd(uabd_pkg::OFS_DIVISOR_HIGH, {25'h0, e[15:8]});
            rd(uabd_pkg::OFS_BAUD_CONTROL, {25'h0, 2'b01, 2'b00, wide, 1'b0, i == 2, 1'b0});
            rd(uabd_pkg::OFS_RX_STATUS, 33'h1);
            rd(uabd_pkg::OFS_RX_HOLDING, 33'h0);
            rd(uabd_pkg::OFS_RX_STATUS, 33'h0);
            $display("test mode %0d done", i);
        end
        print_verdict();
    end
endmodule : uabd_tb
